// [src/pid_dispatch.sv]
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "pid_regs.svh"
module pid_dispatch #(
  parameter bit LARGE_VARIANT = 1'b1 // sources 10..12 fitted
) (
  input wire logic ref_clk_in, // core state clock
  input wire logic nrst_in, // async reset, active low
  input wire logic [7:0] reg_addr_in, // register address
  input wire logic [15:0] reg_wdata_in, // write data
  input wire logic reg_wr_in, // write strobe
  input wire logic reg_rd_in, // read strobe
  output logic [15:0] reg_rdata_out, // read data, next cycle
  input wire logic [14:0] src_event_in, // per-source event pulses
  input wire logic [3:0] shared_evt_in, // shared peripheral events
  input wire logic nmi_pin_in, // nonmaskable pin, async
  input wire logic instr_done_in, // instruction completes
  input wire logic push_all_op_in, // push-all completes
  input wire logic pop_all_op_in, // pop-all completes
  input wire logic enable_irq_op_in, // enable-irq completes
  input wire logic disable_irq_op_in, // disable-irq completes
  input wire logic enable_server_op_in, // enable-server completes
  input wire logic disable_server_op_in, // disable-server completes
  input wire logic unimpl_op_in, // unimplemented opcode seen
  input wire logic trap_op_in, // trap instruction seen
  input wire logic ext_stack_in, // stack is external
  input wire pid_pkg::pid_frame_t pop_frame_in, // frame popped
  input wire logic server_end_in, // server run finished
  input wire logic [3:0] server_end_src_in, // its source
  output pid_pkg::pid_disp_t disp_out, // dispatch descriptor
  output logic disp_valid_out, // dispatch pulse
  output logic push_pc_out, // push pc, load vector
  output pid_pkg::pid_frame_t push_frame_out, // frame to stack
  output logic push_frame_valid_out, // frame pulse
  output logic inhibit_out // calls blocked
);
  localparam int CALL_CYC = `PID_CALL_CYC;
  localparam int CALL_EXT_CYC = `PID_CALL_CYC + `PID_EXT_CYC;
  localparam int IE = `PID_SW_IRQ_EN_BIT;
  localparam int SE = `PID_SW_SRV_EN_BIT;

  pid_pkg::pid_state_t state_q;
  pid_pkg::pid_disp_t disp_q;
  pid_pkg::pid_disp_t win;
  pid_pkg::pid_disp_t special_disp;
  pid_pkg::pid_frame_t push_frame_q;
  logic [3:0] cnt_q;
  logic disp_valid_q;
  logic push_pc_q;
  logic push_frame_valid_q;
  logic inhibit_q;
  logic [15:0] rdata_q;
  logic [15:0] pend_q;
  logic [15:0] core_mask_q;
  logic [15:0] program_status_word_q;
  logic [14:0] service_select_q;
  logic [14:0] eos_req_q;
  logic [3:0] shared_source_mask_q;
  logic [7:0] window_select_q;
  logic nmi_s1_q;
  logic nmi_s2_q;
  logic nmi_s3_q;
  logic [14:0] present;
  logic [14:0] evt;
  logic [14:0] srv_req;
  logic [14:0] std_req;
  logic win_v;
  logic prot_op;
  logic special_now;
  logic take_now;
  logic nmi_edge;
  logic [15:0] pend_clr;
  logic [14:0] eos_clr;
  logic [14:0] eos_set;
  logic wr_pend;
  logic wr_mask;
  logic wr_shmask;
  logic wr_sel;
  logic wr_eos;
  logic wr_sword;
  logic wr_wsel;

  // standard vector word of a maskable source
  function automatic logic [15:0] std_vec(input logic [3:0] s);
    std_vec = (s[3] ? `PID_VEC_STD_HI : `PID_VEC_STD_LO) + {12'h000, s[2:0], 1'b0};
  endfunction

  // write strobes per register
  assign wr_pend = reg_wr_in && (reg_addr_in == `PID_OFF_PEND);
  assign wr_mask = reg_wr_in && (reg_addr_in == `PID_OFF_MASK);
  assign wr_shmask = reg_wr_in && (reg_addr_in == `PID_OFF_SHMASK);
  assign wr_sel = reg_wr_in && (reg_addr_in == `PID_OFF_SEL);
  assign wr_eos = reg_wr_in && (reg_addr_in == `PID_OFF_EOS);
  assign wr_sword = reg_wr_in && (reg_addr_in == `PID_OFF_SWORD);
  assign wr_wsel = reg_wr_in && (reg_addr_in == `PID_OFF_WSEL);

  // nmi pin synchroniser and rising edge detect
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      nmi_s1_q <= 1'b0;
      nmi_s2_q <= 1'b0;
      nmi_s3_q <= 1'b0;
    end else begin
      nmi_s1_q <= nmi_pin_in;
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
    end
  end
  assign nmi_edge = nmi_s2_q & ~nmi_s3_q;

  // per-source presence, events and eligibility
  for (genvar g = 0; g < 15; g++) begin : g_src
    localparam bit FITTED = LARGE_VARIANT || (g < 10) || (g > 12);
    assign present[g] = FITTED;
    if (g == `PID_SHARED_SRC) begin : g_shared
      assign evt[g] = FITTED & (|(shared_evt_in & shared_source_mask_q));
    end else begin : g_plain
      assign evt[g] = FITTED & src_event_in[g];
    end
    assign srv_req[g] = pend_q[g] & core_mask_q[g] & service_select_q[g]
                        & program_status_word_q[SE];
    assign std_req[g] = ((pend_q[g] & ~service_select_q[g]) | eos_req_q[g])
                        & core_mask_q[g] & program_status_word_q[IE];
  end

  // priority encoder, later loop hits outrank earlier ones
  always_comb begin
    win = '0;
    win_v = 1'b0;
    for (int i = 0; i < 15; i++) begin
      if (std_req[i]) begin
        win_v = 1'b1;
        win.kind = pid_pkg::PID_KIND_STD;
        win.src = 4'(i);
        win.rank = 5'(i);
        win.eos = eos_req_q[i];
        win.vector = std_vec(4'(i));
      end
    end
    for (int i = 0; i < 15; i++) begin
      if (srv_req[i]) begin
        win_v = 1'b1;
        win.kind = pid_pkg::PID_KIND_SERVER;
        win.src = 4'(i);
        win.rank = 5'(i + `PID_RANK_SRV_OFS);
        win.eos = 1'b0;
        win.vector = `PID_VEC_SRV + {11'h000, 4'(i), 1'b0};
      end
    end
    if (pend_q[`PID_NMI_SRC]) begin
      win_v = 1'b1;
      win.kind = pid_pkg::PID_KIND_STD;
      win.src = 4'(`PID_NMI_SRC);
      win.rank = `PID_RANK_NMI;
      win.eos = 1'b0;
      win.vector = `PID_VEC_NMI;
    end
  end

  // special interrupts skip the encoder entirely
  always_comb begin
    special_disp = '0;
    special_disp.kind = pid_pkg::PID_KIND_SPECIAL;
    special_disp.vector = unimpl_op_in ? `PID_VEC_UNIMP : `PID_VEC_TRAP;
  end

  // take decision at instruction boundaries
  assign prot_op = instr_done_in & (push_all_op_in | pop_all_op_in | enable_irq_op_in
                   | disable_irq_op_in | enable_server_op_in | disable_server_op_in);
  assign special_now = (state_q == pid_pkg::PID_IDLE) & (unimpl_op_in | trap_op_in);
  assign take_now = (state_q == pid_pkg::PID_IDLE) & instr_done_in & ~inhibit_q
                    & ~prot_op & ~special_now & win_v;

  // clear masks from acknowledge and server completion
  assign pend_clr = (take_now && !win.eos) ? (16'h0001 << win.src) : 16'h0000;
  assign eos_clr = (take_now && win.eos) ? (15'h0001 << win.src) : 15'h0000;
  assign eos_set = server_end_in ? ((15'h0001 << server_end_src_in) & present) : 15'h0000;

  // dispatch sequencer and call timing
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= pid_pkg::PID_IDLE;
      cnt_q <= 4'h0;
      disp_q <= '0;
      disp_valid_q <= 1'b0;
      push_pc_q <= 1'b0;
    end else begin
      disp_valid_q <= 1'b0;
      push_pc_q <= 1'b0;
      case (state_q)
        pid_pkg::PID_IDLE: begin
          if (special_now) begin
            disp_q <= special_disp;
            state_q <= pid_pkg::PID_CALL;
            cnt_q <= ext_stack_in ? 4'(CALL_EXT_CYC - 2) : 4'(CALL_CYC - 2);
          end else if (take_now) begin
            disp_q <= win;
            if (win.kind == pid_pkg::PID_KIND_SERVER) begin
              disp_valid_q <= 1'b1;
            end else begin
              state_q <= pid_pkg::PID_CALL;
              cnt_q <= ext_stack_in ? 4'(CALL_EXT_CYC - 2) : 4'(CALL_CYC - 2);
            end
          end
        end
        pid_pkg::PID_CALL: begin
          if (cnt_q == 4'h0) begin
            disp_valid_q <= 1'b1;
            push_pc_q <= 1'b1;
            state_q <= pid_pkg::PID_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: begin
          state_q <= pid_pkg::PID_IDLE;
        end
      endcase
    end
  end

  // call inhibit window, set wins over clear
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      inhibit_q <= 1'b0;
    end else if (take_now || special_now || prot_op) begin
      inhibit_q <= 1'b1;
    end else if (instr_done_in && state_q == pid_pkg::PID_IDLE) begin
      inhibit_q <= 1'b0;
    end
  end

  // pending flags, events win over clears
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_q <= `PID_RST_PEND;
    end else begin
      pend_q <= ((wr_pend ? (reg_wdata_in & {1'b1, present}) : pend_q) & ~pend_clr)
                | {nmi_edge, evt};
    end
  end

  // end-of-service requests and service select
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      eos_req_q <= `PID_RST_SEL;
      service_select_q <= `PID_RST_SEL;
    end else begin
      eos_req_q <= ((wr_eos ? (reg_wdata_in[14:0] & present) : eos_req_q) & ~eos_clr)
                   | eos_set;
      service_select_q <= (wr_sel ? (reg_wdata_in[14:0] & present) : service_select_q)
                          & ~eos_set;
    end
  end

  // core masks, shared mask and window select
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      core_mask_q <= `PID_RST_MASK;
      shared_source_mask_q <= 4'h0;
      window_select_q <= `PID_RST_WSEL;
    end else begin
      if (wr_shmask) begin
        shared_source_mask_q <= reg_wdata_in[3:0];
      end
      if (pop_all_op_in && instr_done_in) begin
        core_mask_q <= pop_frame_in.mask & {1'b1, present};
        window_select_q <= pop_frame_in.wsel;
      end else if (push_all_op_in && instr_done_in) begin
        core_mask_q <= `PID_RST_MASK;
      end else begin
        if (wr_mask) begin
          core_mask_q <= reg_wdata_in & {1'b1, present};
        end
        if (wr_wsel) begin
          window_select_q <= reg_wdata_in[7:0];
        end
      end
    end
  end

  // status word with enable ops
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      program_status_word_q <= `PID_RST_SWORD;
    end else if (pop_all_op_in && instr_done_in) begin
      program_status_word_q <= pop_frame_in.sword;
    end else if (push_all_op_in && instr_done_in) begin
      program_status_word_q <= `PID_RST_SWORD;
    end else begin
      if (wr_sword) begin
        program_status_word_q <= reg_wdata_in;
      end
      if (enable_irq_op_in && instr_done_in) begin
        program_status_word_q[IE] <= 1'b1;
      end
      if (disable_irq_op_in && instr_done_in) begin
        program_status_word_q[IE] <= 1'b0;
      end
      if (enable_server_op_in && instr_done_in) begin
        program_status_word_q[SE] <= 1'b1;
      end
      if (disable_server_op_in && instr_done_in) begin
        program_status_word_q[SE] <= 1'b0;
      end
    end
  end

  // push-all frame out to the stack
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      push_frame_q <= '0;
      push_frame_valid_q <= 1'b0;
    end else begin
      push_frame_valid_q <= push_all_op_in & instr_done_in;
      if (push_all_op_in && instr_done_in) begin
        push_frame_q <= {program_status_word_q, core_mask_q, window_select_q};
      end
    end
  end

  // registered read mux
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_q <= 16'h0000;
    end else if (!reg_rd_in) begin
      rdata_q <= 16'h0000;
    end else if (reg_addr_in == `PID_OFF_PEND) begin
      rdata_q <= pend_q;
    end else if (reg_addr_in == `PID_OFF_MASK) begin
      rdata_q <= core_mask_q;
    end else if (reg_addr_in == `PID_OFF_SHMASK) begin
      rdata_q <= {12'h000, shared_source_mask_q};
    end else if (reg_addr_in == `PID_OFF_SEL) begin
      rdata_q <= {1'b0, service_select_q};
    end else if (reg_addr_in == `PID_OFF_EOS) begin
      rdata_q <= {1'b0, eos_req_q};
    end else if (reg_addr_in == `PID_OFF_SWORD) begin
      rdata_q <= program_status_word_q;
    end else if (reg_addr_in == `PID_OFF_WSEL) begin
      rdata_q <= {8'h00, window_select_q};
    end else if (reg_addr_in == `PID_OFF_STAT) begin
      rdata_q <= {9'h000, state_q == pid_pkg::PID_CALL, inhibit_q, win.rank};
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  // outputs straight from flops
  assign reg_rdata_out = rdata_q;
  assign disp_out = disp_q;
  assign disp_valid_out = disp_valid_q;
  assign push_pc_out = push_pc_q;
  assign push_frame_out = push_frame_q;
  assign push_frame_valid_out = push_frame_valid_q;
  assign inhibit_out = inhibit_q;

  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_call_int;
    take_now && win.kind == pid_pkg::PID_KIND_STD && !ext_stack_in;
  endsequence
  sequence s_call_ext;
    take_now && win.kind == pid_pkg::PID_KIND_STD && ext_stack_in;
  endsequence
  chk_nmi_top: assert property (win_v && pend_q[15] |-> win.rank == 5'd30)
    else $error("nmi not ranked top");
  chk_server_over: assert property (win_v && !pend_q[15] && (|srv_req)
    |-> win.kind == pid_pkg::PID_KIND_SERVER && win.rank >= 5'd15)
    else $error("server request lost to standard");
  chk_special_path: assert property (special_now && unimpl_op_in
    |=> state_q == pid_pkg::PID_CALL && disp_q.vector == 16'h2012)
    else $error("unimplemented opcode vector wrong");
  chk_call_int_time: assert property (s_call_int |=> !disp_valid_out [*8]
    ##(CALL_CYC - 8) disp_valid_out && push_pc_out)
    else $error("internal stack call timing wrong");
  chk_call_ext_time: assert property (s_call_ext |-> ##CALL_EXT_CYC disp_valid_out)
    else $error("external stack call timing wrong");
  chk_ei_blocks: assert property (enable_irq_op_in && instr_done_in
    |=> program_status_word_q[1] && !take_now)
    else $error("enable-irq did not block one call");
  chk_push_clears: assert property (push_all_op_in && instr_done_in && !pop_all_op_in
    |=> program_status_word_q == 16'h0000 && core_mask_q == 16'h0000
    && push_frame_valid_out)
    else $error("push-all did not clear context");
  chk_pop_restore: assert property (pop_all_op_in && instr_done_in
    |=> program_status_word_q == $past(pop_frame_in.sword))
    else $error("pop-all did not restore status word");
  chk_eos_clear: assert property (take_now && win.eos && !server_end_in && !reg_wr_in
    |=> !eos_req_q[$past(win.src)]
    && (pend_q[$past(win.src)] || !$past(pend_q[win.src])))
    else $error("end-of-service clear wrong");
  chk_sel_drop: assert property (server_end_in && !reg_wr_in && present[server_end_src_in]
    |=> !service_select_q[$past(server_end_src_in)] && eos_req_q[$past(server_end_src_in)])
    else $error("server end did not re-route source");
  chk_reserved: assert property (!LARGE_VARIANT |-> pend_q[12:10] == 3'h0)
    else $error("reserved source pending");
  chk_ie_gate: assert property (!program_status_word_q[1] && !pend_q[15] && win_v
    |-> win.kind == pid_pkg::PID_KIND_SERVER)
    else $error("standard dispatch while disabled");
  chk_masked: assert property (win_v && win.src != 4'hf |-> core_mask_q[win.src])
    else $error("masked source ranked");
endmodule // pid_dispatch

// [src/pid_pkg.sv]
package pid_pkg;
  typedef enum logic [1:0] {
    PID_KIND_NONE,
    PID_KIND_STD,
    PID_KIND_SERVER,
    PID_KIND_SPECIAL
  } pid_kind_t;
  // one dispatch: what kind, which source, its rank and vector word
  typedef struct packed {
    pid_kind_t kind;
    logic eos;
    logic [3:0] src;
    logic [4:0] rank;
    logic [15:0] vector;
  } pid_disp_t;
  // context stacked by push-all and restored by pop-all
  typedef struct packed {
    logic [15:0] sword;
    logic [15:0] mask;
    logic [7:0] wsel;
  } pid_frame_t;
  typedef enum {PID_IDLE, PID_CALL} pid_state_t;
endpackage

// [src/pid_regs.svh]
`ifndef PID_REGS_SVH
`define PID_REGS_SVH
// register offsets on the plain register port
`define PID_OFF_PEND 8'h00
`define PID_OFF_MASK 8'h04
`define PID_OFF_SHMASK 8'h08
`define PID_OFF_SEL 8'h0c
`define PID_OFF_EOS 8'h10
`define PID_OFF_SWORD 8'h14
`define PID_OFF_WSEL 8'h18
`define PID_OFF_STAT 8'h1c
// status word enable bits
`define PID_SW_IRQ_EN_BIT 1
`define PID_SW_SRV_EN_BIT 2
// sources and ranks
`define PID_NMI_SRC 15
`define PID_SHARED_SRC 13
`define PID_RANK_SRV_OFS 15
`define PID_RANK_NMI 5'd30
// vector words
`define PID_VEC_STD_LO 16'h2000
`define PID_VEC_STD_HI 16'h2030
`define PID_VEC_SRV 16'h2040
`define PID_VEC_NMI 16'h203e
`define PID_VEC_TRAP 16'h2010
`define PID_VEC_UNIMP 16'h2012
// call timing in state times, one state time per clock here
`define PID_CLK_NS 4
`define PID_STATE_NS 4
`define PID_CALL_STATES 11
`define PID_EXT_STATES 2
`define PID_CALL_CYC ((`PID_CALL_STATES*`PID_STATE_NS+`PID_CLK_NS-1)/`PID_CLK_NS)
`define PID_EXT_CYC ((`PID_EXT_STATES*`PID_STATE_NS+`PID_CLK_NS-1)/`PID_CLK_NS)
// reset values
`define PID_RST_PEND 16'h0000
`define PID_RST_MASK 16'h0000
`define PID_RST_SWORD 16'h0000
`define PID_RST_SEL 15'h0000
`define PID_RST_WSEL 8'h00
`endif

// [tb/pid_core_model.sv]
`timescale 1ns/1ps
// core sequencer stand-in: retires instructions, stalls and times calls
module pid_core_model #(
  parameter int GAP = 3 // countdown before the next retire, after the post-retire wait (GAP+2 idle cycles when no call)
) (
  input wire logic ref_clk_in, // core clock
  input wire logic nrst_in, // async reset, active low
  input wire logic inhibit_in, // calls blocked
  input wire logic disp_valid_in, // dispatch done
  output logic instr_done_out, // instruction retires
  output logic [4:0] lat_out // cycles from take to dispatch
);
  logic [4:0] cnt_q;
  logic [3:0] gap_q;
  logic wait_q;
  // after each retire, hold still while a call may be running
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      instr_done_out <= 1'b0;
      lat_out <= 5'h00;
      cnt_q <= 5'h00;
      gap_q <= 4'h0;
      wait_q <= 1'b0;
    end else begin
      instr_done_out <= 1'b0;
      if (wait_q) begin
        cnt_q <= cnt_q + 5'h01;
        if (disp_valid_in) begin
          wait_q <= 1'b0;
          lat_out <= cnt_q + 5'h01;
        end else if ((cnt_q == 5'h00 && !inhibit_in) || cnt_q == 5'h10) begin
          wait_q <= 1'b0;
        end
      end else if (instr_done_out) begin
        wait_q <= 1'b1;
        cnt_q <= 5'h00;
      end else if (gap_q == 4'h0) begin
        instr_done_out <= 1'b1;
        gap_q <= 4'(GAP);
      end else begin
        gap_q <= gap_q - 4'h1;
      end
    end
  end
endmodule // pid_core_model

// [tb/tb.sv]
`timescale 1ns/1ps
`include "pid_regs.svh"
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [14:0] ev = 15'h0000;
  logic [3:0] sh = 4'h0;
  logic nmi = 1'b0;
  logic [5:0] ops = 6'h00; // push, pop, irq on, irq off, srv on, srv off
  logic [1:0] spc = 2'h0; // unimplemented, trap
  logic ext = 1'b0;
  logic send = 1'b0;
  logic [3:0] send_src = 4'h0;
  pid_pkg::pid_frame_t popf = '0;
  logic [15:0] rdata;
  pid_pkg::pid_disp_t disp;
  pid_pkg::pid_frame_t pf;
  logic dv, ppc, pfv, inh, idone, pc_seen;
  logic [4:0] lat;
  int err_total = 0;
  int cmp_count = 0;
  // rows: source, server path, external stack, rank, vector
  logic [26:0] rows [7] = '{{4'h0, 2'b00, 5'h00, 16'h2000}, {4'h7, 2'b01, 5'h07, 16'h200e},
    {4'h8, 2'b00, 5'h08, 16'h2030}, {4'he, 2'b00, 5'h0e, 16'h203c},
    {4'h0, 2'b10, 5'h0f, 16'h2040}, {4'h9, 2'b10, 5'h18, 16'h2052},
    {4'he, 2'b10, 5'h1d, 16'h205c}};
  // enable ops and the status word they leave
  logic [21:0] opt [4] = '{{6'h02, 16'h0006}, {6'h01, 16'h0002}, {6'h04, 16'h0000},
    {6'h08, 16'h0002}};

  always #2 clk = ~clk;

  pid_dispatch dut (.ref_clk_in(clk), .nrst_in(nrst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .src_event_in(ev), .shared_evt_in(sh), .nmi_pin_in(nmi), .instr_done_in(idone),
    .push_all_op_in(ops[5]), .pop_all_op_in(ops[4]), .enable_irq_op_in(ops[3]),
    .disable_irq_op_in(ops[2]), .enable_server_op_in(ops[1]),
    .disable_server_op_in(ops[0]), .unimpl_op_in(spc[1]), .trap_op_in(spc[0]),
    .ext_stack_in(ext), .pop_frame_in(popf), .server_end_in(send),
    .server_end_src_in(send_src), .disp_out(disp), .disp_valid_out(dv),
    .push_pc_out(ppc), .push_frame_out(pf), .push_frame_valid_out(pfv),
    .inhibit_out(inh));

  pid_core_model #(.GAP(3)) core (.ref_clk_in(clk), .nrst_in(nrst), .inhibit_in(inh),
    .disp_valid_in(dv), .instr_done_out(idone), .lat_out(lat));

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(40'(rdata), 40'(e));
  endtask

  task automatic fire(input logic [14:0] e, input logic [3:0] s);
    @(posedge clk);
    ev <= e;
    sh <= s;
    @(posedge clk);
    ev <= 15'h0000;
    sh <= 4'h0;
  endtask

  // bounded wait for a dispatch pulse, then step past its edge
  task automatic wait_disp();
    int n;
    n = 0;
    @(negedge clk);
    while (dv !== 1'b1 && n < 80) begin
      n++;
      @(negedge clk);
    end
    if (n == 80) chk(40'h0, 40'h1);
    pc_seen = ppc;
    @(posedge clk);
    #1;
  endtask

  task automatic op_step(input logic [5:0] o);
    @(posedge clk);
    ops <= o;
    @(negedge clk iff idone === 1'b1);
    @(posedge clk);
    ops <= 6'h00;
    #1 chk(40'(inh), 40'h1);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end

  initial begin
    logic [26:0] r;
    pid_pkg::pid_disp_t first;
    repeat (10) @(posedge clk);
    chk(40'({dv, ppc, pfv, inh, disp}), 40'h0);
    nrst <= 1'b1;
    // reset contents and one unmapped offset read zero
    for (int a = 0; a <= 32; a += 4) rd_chk(8'(a), 16'h0000);
    // one source at a time through standard and server paths
    wr_reg(`PID_OFF_SWORD, 16'h0006);
    foreach (rows[i]) begin
      r = rows[i];
      wr_reg(`PID_OFF_MASK, 16'h0001 << r[26:23]);
      wr_reg(`PID_OFF_SEL, r[22] ? 16'h0001 << r[26:23] : 16'h0000);
      ext <= r[21];
      fire(15'h0001 << r[26:23], 4'h0);
      wait_disp();
      chk(40'(disp), 40'({r[22] ? pid_pkg::PID_KIND_SERVER : pid_pkg::PID_KIND_STD,
        1'b0, r[26:23], r[20:0]}));
      chk(40'(lat), r[22] ? 40'h1 : (r[21] ? 40'hd : 40'hb));
      chk(40'(pc_seen), 40'(!r[22]));
      rd_chk(`PID_OFF_PEND, 16'h0000);
    end
    // two standard requests: higher first, lower left pending
    wr_reg(`PID_OFF_MASK, 16'h0208);
    fire(15'h0208, 4'h0);
    wait_disp();
    chk(40'(disp.src), 40'h9);
    rd_chk(`PID_OFF_PEND, 16'h0008);
    wait_disp();
    chk(40'(disp.src), 40'h3);
    // enables off hold requests back; nmi ignores them and wins
    wr_reg(`PID_OFF_SWORD, 16'h0000);
    wr_reg(`PID_OFF_MASK, 16'h1004);
    wr_reg(`PID_OFF_SEL, 16'h0004);
    fire(15'h1004, 4'h0);
    repeat (20) @(posedge clk);
    rd_chk(`PID_OFF_PEND, 16'h1004);
    @(posedge clk);
    nmi <= 1'b1;
    wait_disp();
    chk(40'({disp.src, disp.rank, disp.vector}), 40'({4'hf, 5'h1e, 16'h203e}));
    @(posedge clk);
    nmi <= 1'b0;
    wr_reg(`PID_OFF_SWORD, 16'h0006);
    wait_disp();
    chk(40'(disp), 40'({pid_pkg::PID_KIND_SERVER, 1'b0, 4'h2, 5'h11, 16'h2044}));
    wait_disp();
    chk(40'(disp.src), 40'hc);
    // shared events reach source 13 only through the shared mask
    wr_reg(`PID_OFF_MASK, 16'h2000);
    wr_reg(`PID_OFF_SHMASK, 16'h0001);
    rd_chk(`PID_OFF_SHMASK, 16'h0001);
    fire(15'h2000, 4'h2);
    repeat (20) @(posedge clk);
    rd_chk(`PID_OFF_PEND, 16'h0000);
    fire(15'h0000, 4'h1);
    wait_disp();
    chk(40'({disp.src, disp.rank, disp.vector}), 40'({4'hd, 5'h0d, 16'h203a}));
    // trap, unimplemented, both at once
    for (int s = 1; s < 4; s++) begin
      @(posedge clk);
      spc <= 2'(s);
      @(posedge clk);
      spc <= 2'h0;
      wait_disp();
      chk(40'({pc_seen, disp.kind, disp.vector}), 40'({1'b1, pid_pkg::PID_KIND_SPECIAL,
        s == 1 ? 16'h2010 : 16'h2012}));
    end
    // end of a server run beside a conventional request of the same source
    wr_reg(`PID_OFF_SWORD, 16'h0000);
    wr_reg(`PID_OFF_MASK, 16'h0020);
    wr_reg(`PID_OFF_SEL, 16'h0020);
    send <= 1'b1;
    send_src <= 4'h5;
    @(posedge clk);
    send <= 1'b0;
    rd_chk(`PID_OFF_SEL, 16'h0000);
    rd_chk(`PID_OFF_PEND, 16'h0000);
    fire(15'h0020, 4'h0);
    rd_chk(`PID_OFF_EOS, 16'h0020);
    wr_reg(`PID_OFF_SWORD, 16'h0002);
    wait_disp();
    first = disp;
    chk(40'({first.src, first.vector}), 40'h5200a);
    wait_disp();
    chk(40'({first.eos ^ disp.eos, disp.src}), 40'h15);
    rd_chk(`PID_OFF_EOS, 16'h0000);
    wr_reg(`PID_OFF_SEL, 16'h0020);
    // push-all stacks context and clears word and core mask
    wr_reg(`PID_OFF_SWORD, 16'h0006);
    wr_reg(`PID_OFF_MASK, 16'h0200);
    wr_reg(`PID_OFF_WSEL, 16'h005a);
    op_step(6'h20);
    chk(40'(pfv), 40'h1);
    chk(40'(pf), {16'h0006, 16'h0200, 8'h5a});
    rd_chk(`PID_OFF_SWORD, 16'h0000);
    rd_chk(`PID_OFF_MASK, 16'h0000);
    // pop-all restores a frame; enable ops flip status bits
    @(posedge clk);
    popf <= {16'h0002, 16'h0010, 8'h33};
    op_step(6'h10);
    rd_chk(`PID_OFF_SWORD, 16'h0002);
    rd_chk(`PID_OFF_MASK, 16'h0010);
    rd_chk(`PID_OFF_WSEL, 16'h0033);
    foreach (opt[i]) begin
      op_step(opt[i][21:16]);
      rd_chk(`PID_OFF_SWORD, opt[i][15:0]);
    end
    give_verdict();
  end
endmodule // tb
